// file: hw/nfbhc_defines.svh
// timing counts, command codes and limits of the nand host controller
`ifndef NFBHC_DEFINES_SVH
`define NFBHC_DEFINES_SVH

// clock rate of SYS_CLK
`define NFBHC_CLK_MHZ        100

// strobe timing in ns as printed
`define NFBHC_T_WP_NS        25
`define NFBHC_T_WH_NS        15
`define NFBHC_T_WHR_NS       60
`define NFBHC_T_REA_NS       30
`define NFBHC_T_REH_NS       15
`define NFBHC_T_WB_NS        100
`define NFBHC_T_CEH_NS       100

// least times round up to whole cycles
`define NFBHC_CYC_UP(ns)     (((ns) * `NFBHC_CLK_MHZ + 999) / 1000)
`define NFBHC_SYNC_CYC       2
`define NFBHC_WR_LOW_CYC     `NFBHC_CYC_UP(`NFBHC_T_WP_NS)
`define NFBHC_WR_HIGH_CYC    `NFBHC_CYC_UP(`NFBHC_T_WH_NS)
`define NFBHC_CMD_HIGH_CYC   `NFBHC_CYC_UP(`NFBHC_T_WHR_NS)
`define NFBHC_RD_LOW_CYC     (`NFBHC_CYC_UP(`NFBHC_T_REA_NS) + `NFBHC_SYNC_CYC)
`define NFBHC_RD_HIGH_CYC    `NFBHC_CYC_UP(`NFBHC_T_REH_NS)
`define NFBHC_WB_CYC         (`NFBHC_CYC_UP(`NFBHC_T_WB_NS) + `NFBHC_SYNC_CYC)
`define NFBHC_CEH_CYC        `NFBHC_CYC_UP(`NFBHC_T_CEH_NS)

// command bytes
`define NFBHC_CMD_READ_A     8'h00
`define NFBHC_CMD_READ_B     8'h01
`define NFBHC_CMD_READ_C     8'h50
`define NFBHC_CMD_PROG       8'h80
`define NFBHC_CMD_PROG_GO    8'h10
`define NFBHC_CMD_ERASE      8'h60
`define NFBHC_CMD_ERASE_GO   8'hD0
`define NFBHC_CMD_STATUS     8'h70

// array limits
`define NFBHC_BLOCKS         2048
`define NFBHC_MIN_VALID      2013
`define NFBHC_NOP_MAIN       2
`define NFBHC_NOP_SPARE      3
`define NFBHC_SPARE_COL      512
`define NFBHC_HALF_COL       256
`define NFBHC_FAIL_BIT       0

`endif

// file: hw/nfbhc_pkg.sv
// types shared by the nand host controller modules
package nfbhc_pkg;

  typedef enum logic [2:0] {
    NFBHC_OP_READ   = 3'b000,
    NFBHC_OP_PROG   = 3'b001,
    NFBHC_OP_ERASE  = 3'b010,
    NFBHC_OP_MARK   = 3'b011,
    NFBHC_OP_STATUS = 3'b100
  } nfbhc_op_t;

  typedef enum logic [1:0] {
    NFBHC_KIND_CMD  = 2'b00,
    NFBHC_KIND_ADDR = 2'b01,
    NFBHC_KIND_WR   = 2'b10,
    NFBHC_KIND_RD   = 2'b11
  } nfbhc_kind_t;

  typedef enum logic [1:0] {
    NFBHC_PH_IDLE = 2'b00,
    NFBHC_PH_LOW  = 2'b01,
    NFBHC_PH_HIGH = 2'b10
  } nfbhc_phase_t;

  typedef enum logic [3:0] {
    NFBHC_S_IDLE   = 4'b0000,
    NFBHC_S_CHECK  = 4'b0001,
    NFBHC_S_PTR    = 4'b0010,
    NFBHC_S_CMD1   = 4'b0011,
    NFBHC_S_ADDR   = 4'b0100,
    NFBHC_S_WDATA  = 4'b0101,
    NFBHC_S_CMD2   = 4'b0110,
    NFBHC_S_WAITWB = 4'b0111,
    NFBHC_S_WAITRB = 4'b1000,
    NFBHC_S_RDATA  = 4'b1001,
    NFBHC_S_STCMD  = 4'b1010,
    NFBHC_S_STRD   = 4'b1011,
    NFBHC_S_FINISH = 4'b1100
  } nfbhc_state_t;

  typedef struct packed {
    nfbhc_op_t   op;
    logic [10:0] block;
    logic [4:0]  page;
    logic [9:0]  column;
    logic [9:0]  len;
  } nfbhc_req_t;

  typedef struct packed {
    logic       refused;
    logic       fail;
    logic [7:0] status;
  } nfbhc_resp_t;

endpackage

// file: hw/nfbhc_cycle.sv
// one strobed bus cycle on the flash pins: command, address, data write or data read
`timescale 1ns/1ns
`include "nfbhc_defines.svh"

module nfbhc_cycle
  import nfbhc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  nfbhc_kind_t      kind,
  input  wire logic [7:0]  wbyte,
  input  wire logic [7:0]  io_sync,
  output logic             idle,
  output logic             done,
  output logic [7:0]       rbyte,
  output logic             cle,
  output logic             ale,
  output logic             we_n,
  output logic             read_strobe_n,
  output logic             io_oe,
  output logic [7:0]       io_out
);

  nfbhc_phase_t phase;
  nfbhc_kind_t  kind_q;
  logic [3:0]   cnt;

  // phase lengths; a command gets the long recovery so a status read may follow
  wire       is_rd    = (kind_q == NFBHC_KIND_RD);
  wire [3:0] low_len  = (kind == NFBHC_KIND_RD) ? 4'(`NFBHC_RD_LOW_CYC) : 4'(`NFBHC_WR_LOW_CYC);
  wire [3:0] high_len = is_rd ? 4'(`NFBHC_RD_HIGH_CYC) :
                        (kind_q == NFBHC_KIND_CMD) ? 4'(`NFBHC_CMD_HIGH_CYC) :
                        4'(`NFBHC_WR_HIGH_CYC);

  assign idle = (phase == NFBHC_PH_IDLE);
  assign done = (phase == NFBHC_PH_HIGH) && (cnt == 4'h0);

  // latch selects and data stay put through the high phase for hold time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase         <= NFBHC_PH_IDLE;
      kind_q        <= NFBHC_KIND_CMD;
      cnt           <= 4'h0;
      rbyte         <= 8'h00;
      cle           <= 1'b0;
      ale           <= 1'b0;
      we_n          <= 1'b1;
      read_strobe_n <= 1'b1;
      io_oe         <= 1'b0;
      io_out        <= 8'h00;
    end else begin
      case (phase)
        NFBHC_PH_IDLE: begin
          if (start) begin
            phase         <= NFBHC_PH_LOW;
            kind_q        <= kind;
            cnt           <= low_len - 4'h1;
            io_out        <= wbyte;
            cle           <= (kind == NFBHC_KIND_CMD);     // see R10
            ale           <= (kind == NFBHC_KIND_ADDR);    // see R10
            io_oe         <= (kind != NFBHC_KIND_RD);
            we_n          <= (kind == NFBHC_KIND_RD);
            read_strobe_n <= (kind != NFBHC_KIND_RD);
          end
        end
        NFBHC_PH_LOW: begin
          if (cnt == 4'h0) begin
            phase         <= NFBHC_PH_HIGH;
            cnt           <= high_len - 4'h1;
            we_n          <= 1'b1;                         // see R9
            read_strobe_n <= 1'b1;
            if (is_rd) begin
              rbyte <= io_sync;   // pin seen through the synchroniser delay
            end
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        NFBHC_PH_HIGH: begin
          if (cnt == 4'h0) begin
            phase <= NFBHC_PH_IDLE;
            cle   <= 1'b0;
            ale   <= 1'b0;
            io_oe <= 1'b0;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          phase <= NFBHC_PH_IDLE;
        end
      endcase
    end
  end

endmodule // nfbhc_cycle

// file: hw/nfbhc_top.sv
// nand flash host sequencer with bad-block table and partial-program tracking
// What this block does
// R1 - block zero is never retired or marked
// R2 - refuse program or erase to bad blocks
// R3 - count valid blocks, flag below 2013
// R4 - retire blocks failing program or erase status
// R5 - at most 2 main partial programs per page; only the most recently programmed page is tracked
// R6 - at most 3 spare partial programs per page; only the most recently programmed page is tracked
// R7 - chip select held low through busy read
// R8 - write protect low except program or erase
// R9 - words latched on write strobe rising edge
// R10 - latch selects mark command or address cycles
// R11 - erase two row cycles, others a column cycle and two row cycles
// R12 - never send surplus address cycles
`timescale 1ns/1ns
`include "nfbhc_defines.svh"

module nfbhc_top
  import nfbhc_pkg::*;
#(
  parameter int NBLK = `NFBHC_BLOCKS
)
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  nfbhc_req_t       REQ,
  input  wire logic        WR_VALID,
  output logic             WR_READY,
  input  wire logic [7:0]  WR_DATA,
  output logic             RD_VALID,
  output logic [7:0]       RD_DATA,
  output logic             RESP_VALID,
  output nfbhc_resp_t      RESP,
  output logic [11:0]      VALID_BLOCK_COUNT,
  output logic             VALID_BELOW_MIN,
  output logic             CE_N,
  output logic             CLE,
  output logic             ALE,
  output logic             WE_N,
  output logic             READ_STROBE_N,
  output logic             WP_N,
  output logic [7:0]       IO_OUT,
  output logic             IO_OE,
  input  wire logic [7:0]  IO_IN,
  input  wire logic        RB_N
);

  nfbhc_state_t state;
  nfbhc_req_t   req;
  logic [9:0]   idx;
  logic [3:0]   wait_cnt;
  logic [7:0]   io_s1, io_s2;
  logic         rb_s1, rb_s2;
  logic [NBLK-1:0] bad;
  logic         trk_valid;
  logic [10:0]  trk_block;
  logic [4:0]   trk_page;
  logic [1:0]   trk_main, trk_spare;
  logic         eng_idle, eng_done;
  logic [7:0]   eng_rbyte;

  // pin inputs pass two flops before anything looks at them
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
    end else begin
      io_s1 <= IO_IN;
      io_s2 <= io_s1;
      rb_s1 <= RB_N;
      rb_s2 <= rb_s1;
    end
  end

  // request decode
  wire is_prog   = (req.op == NFBHC_OP_PROG);
  wire is_erase  = (req.op == NFBHC_OP_ERASE);
  wire is_read   = (req.op == NFBHC_OP_READ);
  wire is_spare  = (req.column >= 10'(`NFBHC_SPARE_COL));
  wire [15:0] row = {req.block, req.page};
  wire [9:0]  nadr = is_erase ? 10'h002 : 10'h003;                   // see R11
  wire        last_adr = (idx == nadr - 10'h001);                   // see R12
  wire        last_dat = (idx == req.len - 10'h001) || (req.len == 10'h000);
  wire        blk_bad  = bad[req.block];
  wire        same_pg  = trk_valid && (trk_block == req.block) && (trk_page == req.page);
  wire        nop_full = same_pg && (is_spare ? (trk_spare >= 2'(`NFBHC_NOP_SPARE))   // see R6
                                              : (trk_main >= 2'(`NFBHC_NOP_MAIN)));   // see R5
  wire        refuse   = (is_prog || is_erase) && (blk_bad || (is_prog && nop_full));  // see R2
  wire        st_fail  = eng_rbyte[`NFBHC_FAIL_BIT];

  // byte chosen for each address cycle; erase starts at the row
  wire [7:0] adr_byte = is_erase ? ((idx == 10'h000) ? row[7:0] : row[15:8]) :
                        (idx == 10'h000) ? req.column[7:0] :
                        (idx == 10'h001) ? row[7:0] : row[15:8];
  // pointer command selects first half, second half or spare area
  wire [7:0] ptr_cmd  = is_spare ? `NFBHC_CMD_READ_C :
                        (req.column >= 10'(`NFBHC_HALF_COL)) ? `NFBHC_CMD_READ_B :
                        `NFBHC_CMD_READ_A;

  // what the engine is asked to do in each state
  wire cyc_state = (state == NFBHC_S_PTR) || (state == NFBHC_S_CMD1) ||
                   (state == NFBHC_S_ADDR) || (state == NFBHC_S_CMD2) ||
                   (state == NFBHC_S_RDATA) || (state == NFBHC_S_STCMD) ||
                   (state == NFBHC_S_STRD) || (state == NFBHC_S_WDATA);
  wire eng_start = cyc_state && eng_idle && ((state != NFBHC_S_WDATA) || WR_VALID);
  nfbhc_kind_t eng_kind;
  assign eng_kind = (state == NFBHC_S_ADDR) ? NFBHC_KIND_ADDR :
                    (state == NFBHC_S_WDATA) ? NFBHC_KIND_WR :
                    ((state == NFBHC_S_RDATA) || (state == NFBHC_S_STRD)) ? NFBHC_KIND_RD :
                    NFBHC_KIND_CMD;
  wire [7:0] eng_byte = (state == NFBHC_S_PTR) ? ptr_cmd :
                        (state == NFBHC_S_CMD1) ? (is_erase ? `NFBHC_CMD_ERASE : `NFBHC_CMD_PROG) :
                        (state == NFBHC_S_CMD2) ? (is_erase ? `NFBHC_CMD_ERASE_GO
                                                            : `NFBHC_CMD_PROG_GO) :
                        (state == NFBHC_S_STCMD) ? `NFBHC_CMD_STATUS :
                        (state == NFBHC_S_ADDR) ? adr_byte : WR_DATA;

  // handshakes and pin-level controls
  assign REQ_READY = (state == NFBHC_S_IDLE);
  assign WR_READY  = (state == NFBHC_S_WDATA) && eng_idle;
  // chip select stays low from first cycle to last, busy included: safe on every variant
  assign CE_N      = (state == NFBHC_S_IDLE) || (state == NFBHC_S_CHECK) ||
                     (state == NFBHC_S_FINISH);                                 // see R7
  // protection lifts only while a program or erase is in flight
  assign WP_N      = !CE_N && (is_prog || is_erase);                            // see R8

  // bad-block marking: scan result from software, or a failed status
  wire mark_scan = (state == NFBHC_S_CHECK) && (req.op == NFBHC_OP_MARK);
  wire mark_fail = (state == NFBHC_S_STRD) && eng_done && (is_prog || is_erase) && st_fail; // see R4
  wire mark_en   = (mark_scan || mark_fail) && (req.block != 11'h000);          // see R1
  wire mark_new  = mark_en && !bad[req.block];

  genvar gi;
  generate
    for (gi = 0; gi < NBLK; gi++) begin : g_bad
      always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          bad[gi] <= 1'b0;
        end else if (mark_en && (req.block == 11'(gi))) begin
          bad[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // valid block tally and its guaranteed floor
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      VALID_BLOCK_COUNT <= 12'(NBLK);
    end else if (mark_new) begin
      VALID_BLOCK_COUNT <= VALID_BLOCK_COUNT - 12'h001;                        // see R3
    end
  end
  assign VALID_BELOW_MIN = (VALID_BLOCK_COUNT < 12'(`NFBHC_MIN_VALID));         // see R3

  // partial-program counts of the most recently programmed page only;
  // a page left and revisited before erase is not remembered
  wire prog_go = (state == NFBHC_S_CHECK) && is_prog && !refuse;
  wire erase_trk = (state == NFBHC_S_CHECK) && is_erase && !refuse && (req.block == trk_block);
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trk_valid <= 1'b0;
      trk_block <= 11'h000;
      trk_page  <= 5'h00;
      trk_main  <= 2'h0;
      trk_spare <= 2'h0;
    end else if (prog_go) begin
      trk_valid <= 1'b1;
      trk_block <= req.block;
      trk_page  <= req.page;
      trk_main  <= (same_pg ? trk_main : 2'h0) + {1'b0, !is_spare};             // see R5
      trk_spare <= (same_pg ? trk_spare : 2'h0) + {1'b0, is_spare};             // see R6
    end else if (erase_trk) begin
      trk_valid <= 1'b0;
    end
  end

  // sequencer
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state      <= NFBHC_S_IDLE;
      req        <= '0;
      idx        <= 10'h000;
      wait_cnt   <= 4'h0;
      RD_VALID   <= 1'b0;
      RD_DATA    <= 8'h00;
      RESP_VALID <= 1'b0;
      RESP       <= '0;
    end else begin
      RD_VALID   <= 1'b0;
      RESP_VALID <= 1'b0;
      case (state)
        NFBHC_S_IDLE: begin
          idx <= 10'h000;
          wait_cnt <= 4'h0;
          if (REQ_VALID) begin
            req   <= REQ;
            state <= NFBHC_S_CHECK;
          end
        end
        NFBHC_S_CHECK: begin
          RESP <= '0;
          if (refuse) begin
            RESP.refused <= 1'b1;                                               // see R2
            state        <= NFBHC_S_FINISH;
          end else begin
            case (req.op)
              NFBHC_OP_MARK:   state <= NFBHC_S_FINISH;
              NFBHC_OP_STATUS: state <= NFBHC_S_STCMD;
              NFBHC_OP_ERASE:  state <= NFBHC_S_CMD1;
              default:         state <= NFBHC_S_PTR;
            endcase
          end
        end
        NFBHC_S_PTR: if (eng_done) state <= is_read ? NFBHC_S_ADDR : NFBHC_S_CMD1;
        NFBHC_S_CMD1: if (eng_done) state <= NFBHC_S_ADDR;
        NFBHC_S_ADDR: begin
          if (eng_done) begin
            idx <= last_adr ? 10'h000 : idx + 10'h001;                          // see R12
            if (last_adr) begin
              state <= is_erase ? NFBHC_S_CMD2 :
                       is_prog  ? ((req.len == 10'h000) ? NFBHC_S_CMD2 : NFBHC_S_WDATA) :
                       NFBHC_S_WAITWB;
            end
          end
        end
        NFBHC_S_WDATA: begin
          if (eng_done) begin
            idx <= idx + 10'h001;
            if (last_dat) state <= NFBHC_S_CMD2;
          end
        end
        NFBHC_S_CMD2: begin
          if (eng_done) begin
            state    <= NFBHC_S_WAITWB;
            wait_cnt <= 4'h0;
          end
        end
        NFBHC_S_WAITWB: begin
          // busy only shows after the strobe-to-busy delay plus sync flops
          wait_cnt <= wait_cnt + 4'h1;
          if (wait_cnt == 4'(`NFBHC_WB_CYC)) state <= NFBHC_S_WAITRB;
        end
        NFBHC_S_WAITRB: begin
          idx <= 10'h000;
          if (rb_s2) begin
            state <= is_read ? ((req.len == 10'h000) ? NFBHC_S_FINISH : NFBHC_S_RDATA)
                             : NFBHC_S_STCMD;
          end
        end
        NFBHC_S_RDATA: begin
          if (eng_done) begin
            RD_VALID <= 1'b1;
            RD_DATA  <= eng_rbyte;
            idx      <= last_dat ? 10'h000 : idx + 10'h001;
            if (last_dat) state <= NFBHC_S_FINISH;
          end
        end
        NFBHC_S_STCMD: if (eng_done) state <= NFBHC_S_STRD;
        NFBHC_S_STRD: begin
          if (eng_done) begin
            RESP.status <= eng_rbyte;
            RESP.fail   <= (is_prog || is_erase) && st_fail;
            state       <= NFBHC_S_FINISH;
          end
        end
        NFBHC_S_FINISH: begin
          // chip select high long enough to end any sequential read
          wait_cnt <= (idx == 10'h000) ? 4'h0 : wait_cnt + 4'h1;
          idx      <= 10'h001;
          if ((idx != 10'h000) && (wait_cnt == 4'(`NFBHC_CEH_CYC))) begin
            RESP_VALID <= 1'b1;
            state      <= NFBHC_S_IDLE;
          end
        end
        default: state <= NFBHC_S_IDLE;
      endcase
    end
  end

  nfbhc_cycle u_cycle (
    .clk           (SYS_CLK),
    .rst_n         (RST_N),
    .start         (eng_start),
    .kind          (eng_kind),
    .wbyte         (eng_byte),
    .io_sync       (io_s2),
    .idle          (eng_idle),
    .done          (eng_done),
    .rbyte         (eng_rbyte),
    .cle           (CLE),
    .ale           (ALE),
    .we_n          (WE_N),
    .read_strobe_n (READ_STROBE_N),
    .io_oe         (IO_OE),
    .io_out        (IO_OUT)
  );

endmodule // nfbhc_top

// file: test/nfbhc_properties.sv
// concurrent checks on the nand host controller pins
`timescale 1ns/1ns

module nfbhc_checker
  import nfbhc_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        RESP_VALID,
  input  nfbhc_resp_t      RESP,
  input  wire logic [11:0] VALID_BLOCK_COUNT,
  input  wire logic        VALID_BELOW_MIN,
  input  wire logic        CE_N,
  input  wire logic        CLE,
  input  wire logic        ALE,
  input  wire logic        WE_N,
  input  wire logic        WP_N,
  input  wire logic [7:0]  IO_OUT,
  input  wire logic        RB_N
);
  // one clock domain, all checks sleep through reset
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  chk_we_under_ce: assert property (!WE_N |-> !CE_N)
    else $error("write strobe low without chip select");
  chk_we_width: assert property ($fell(WE_N) |-> (!WE_N)[*3] ##1 WE_N)
    else $error("write strobe low phase not three cycles");
  chk_latch_excl: assert property (CLE |-> !ALE)
    else $error("both latch selects high");
  chk_latch_hold: assert property (!WE_N |=> $stable(CLE) && $stable(ALE) && $stable(IO_OUT))
    else $error("latch selects or bus moved under write strobe");
  chk_wp_idle_low: assert property (CE_N |-> !WP_N)
    else $error("write protect released outside an operation");
  chk_ce_busy: assert property (!CE_N && !RB_N |=> !CE_N)
    else $error("chip select dropped while device busy");
  chk_refuse_quiet: assert property (RESP_VALID && RESP.refused |-> $past(CE_N, 2) && $past(CE_N, 11))
    else $error("refused request touched the flash");
  chk_count_step: assert property ($changed(VALID_BLOCK_COUNT) |-> VALID_BLOCK_COUNT == $past(VALID_BLOCK_COUNT) - 12'h001)
    else $error("valid count moved by other than one");
  chk_below_min: assert property (VALID_BELOW_MIN == (VALID_BLOCK_COUNT < 12'h7DD))
    else $error("below-minimum flag disagrees with count");
endmodule // nfbhc_checker

bind nfbhc_top nfbhc_checker u_chk (.SYS_CLK, .RST_N, .RESP_VALID, .RESP, .VALID_BLOCK_COUNT,
  .VALID_BELOW_MIN, .CE_N, .CLE, .ALE, .WE_N, .WP_N, .IO_OUT, .RB_N);

// file: test/nfbhc_flash_model.sv
// behavioural nand flash device answering the host controller pins
`timescale 1ns/1ns

module nfbhc_flash_model (
  input  wire logic        ce_n,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        we_n,
  input  wire logic        read_strobe_n,
  input  wire logic        wp_n,
  input  wire logic [7:0]  io,
  input  wire logic [10:0] fail_blk,
  input  wire logic [31:0] busy_ns,
  output logic [7:0]       dev_io = 8'h5A,
  output logic             rb_n = 1'b1,
  output int               addr_cnt = 0,
  output int               data_cnt = 0,
  output int               exec_cnt = 0,
  output logic [15:0]      row = 16'h0000
);
  logic [7:0] adr [0:2];
  logic [7:0] cmd = 8'h00;
  logic       fail = 1'b0;
  logic       st_mode = 1'b0;
  int         col = 0;

  // busy runs on its own timer, strobes cannot cut it short
  task automatic go_busy();
    rb_n <= #20 1'b0;
    rb_n <= #(40 + busy_ns) 1'b1;
  endtask

  // words taken only at a write strobe rise with chip select low
  always @(posedge we_n) begin
    if (!ce_n && cle && !ale) begin
      cmd = io;
      st_mode = (io == 8'h70);
      if (io != 8'h70 && io != 8'h10 && io != 8'hD0) begin
        addr_cnt = 0;
        data_cnt = 0;
      end
      if (io == 8'h00 || io == 8'h01 || io == 8'h50)
        col = (io == 8'h50) ? 512 : (io == 8'h01) ? 256 : 0;
      if ((io == 8'h10 || io == 8'hD0) && wp_n) begin
        exec_cnt++;
        row = (io == 8'hD0) ? {adr[1], adr[0]} : {adr[2], adr[1]};
        fail = (row[15:5] == fail_blk) && (row[15:5] != 11'h000);
        go_busy();
      end
    end else if (!ce_n && ale && !cle) begin
      if (addr_cnt < 3) adr[addr_cnt] = io;
      addr_cnt++;
      if (addr_cnt == 3 && cmd != 8'h80 && cmd != 8'h60) begin
        row = {adr[2], adr[1]};
        col = col + adr[0];
        go_busy();
      end
    end else if (!ce_n && !cle && !ale) begin
      data_cnt++;
    end
  end

  // byte valid after strobe fall, scrambled once hold ends
  always @(negedge read_strobe_n) begin
    if (!ce_n) begin
      dev_io <= #20 st_mode ? {7'h60, fail} : 8'(col) ^ row[7:0];
      if (!st_mode) col++;
    end
  end
  always @(posedge read_strobe_n) dev_io <= #15 ~dev_io;
endmodule // nfbhc_flash_model

// file: test/nfbhc_top_bench.sv
// self-checking bench for the nand host controller and flash model
`timescale 1ns/1ns

module nfbhc_top_bench
  import nfbhc_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n, req_valid, wr_valid, req_ready, wr_ready, rd_valid, resp_valid;
  logic        below_min, ce_n, cle, ale, we_n, rs_n, wp_n, io_oe, rb_n;
  logic [7:0]  wr_data, rd_data, io_out, dev_io, io_bus;
  logic [10:0] fail_blk;
  logic [11:0] valid_cnt;
  logic [15:0] f_row, last_pg;
  nfbhc_req_t  req;
  nfbhc_resp_t resp;
  int          busy_ns, f_addr, f_data, f_exec, k;
  int          errors = 0, total_checks = 0, seed = 24;
  int          cnt = 2048, n_main = 0, n_spare = 0, exp_exec = 0;
  bit          bad [0:2047];
  bit          pg_valid = 0;
  logic [7:0]  rx [$];

  nfbhc_top dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ(req), .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .RESP_VALID(resp_valid), .RESP(resp), .VALID_BLOCK_COUNT(valid_cnt),
    .VALID_BELOW_MIN(below_min), .CE_N(ce_n), .CLE(cle), .ALE(ale), .WE_N(we_n),
    .READ_STROBE_N(rs_n), .WP_N(wp_n), .IO_OUT(io_out), .IO_OE(io_oe), .IO_IN(io_bus), .RB_N(rb_n));
  // output enable owner drives the data lines
  assign io_bus = io_oe ? io_out : dev_io;
  nfbhc_flash_model flash (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(rs_n),
    .wp_n(wp_n), .io(io_bus), .fail_blk(fail_blk), .busy_ns(busy_ns), .dev_io(dev_io),
    .rb_n(rb_n), .addr_cnt(f_addr), .data_cnt(f_data), .exec_cnt(f_exec), .row(f_row));

  always #5 sys_clk = ~sys_clk;

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic timeout();
    errors++;
    $display("MISMATCH %0t wait ran out", $time);
    end_sim();
  endtask

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input nfbhc_resp_t got, input logic er, input logic ef,
                          input logic [7:0] es);
    total_checks++;
    if (got !== {er, ef, es}) begin
      errors++;
      $display("MISMATCH %0t response %h expected %h", $time, got, {er, ef, es});
    end
  endtask

  // one request end to end, reference worked out first
  task automatic do_req(input nfbhc_op_t op, input logic [10:0] blk, input logic [4:0] pg,
                        input logic [9:0] col, input logic [9:0] len);
    int          n;
    int          wn;
    bit          rf, fl, pr, er;
    logic [15:0] rw;
    rw = {blk, pg};
    wn = 0;
    rx.delete();
    pr = (op == NFBHC_OP_PROG);
    er = (op == NFBHC_OP_ERASE);
    rf = (pr || er) && bad[blk];
    if (pr && !rf && pg_valid && last_pg == rw)
      rf = (col < 10'h200) ? (n_main >= 2) : (n_spare >= 3);
    if (pr && !rf) begin
      if (!(pg_valid && last_pg == rw)) begin
        n_main = 0;
        n_spare = 0;
      end
      last_pg = rw;
      pg_valid = 1;
      if (col < 10'h200) n_main++;
      else n_spare++;
    end
    if (er && !rf && last_pg[15:5] == blk) pg_valid = 0;
    fl = (pr || er) && !rf && blk == fail_blk && blk != 11'h000;
    if ((fl || op == NFBHC_OP_MARK) && blk != 11'h000 && !bad[blk]) begin
      bad[blk] = 1;
      cnt--;
    end
    if ((pr || er) && !rf) exp_exec++;
    @(posedge sys_clk);
    req <= {op, blk, pg, col, len};
    req_valid <= 1'b1;
    wr_valid <= pr && len != 10'h000;
    wr_data <= rw[7:0];
    for (n = 0; n < 100 && !(req_valid && req_ready); n++) @(posedge sys_clk);
    if (n == 100) timeout();
    req_valid <= 1'b0;
    for (n = 0; n < 20000; n++) begin
      @(posedge sys_clk);
      if (wr_valid && wr_ready) begin
        wn++;
        wr_data <= rw[7:0] ^ 8'(wn);
        if (wn == len) wr_valid <= 1'b0;
      end
      if (rd_valid) rx.push_back(rd_data);
      if (resp_valid) break;
    end
    if (n == 20000) timeout();
    #1;
    cmp_resp(resp, rf, fl, ((pr || er) && !rf || op == NFBHC_OP_STATUS) ? {7'h60, fl}
             : 8'h00);
    cmp_val(16'(valid_cnt), 16'(cnt));
    cmp_val(16'(below_min), 16'(cnt < 2013));
    cmp_val(16'(f_exec), 16'(exp_exec));
    if (!rf && op != NFBHC_OP_MARK && op != NFBHC_OP_STATUS) begin
      cmp_val(16'(f_addr), er ? 16'h0002 : 16'h0003);
      cmp_val(16'(f_row[15:5]), 16'(blk));
    end
    if (pr && !rf) cmp_val(16'(f_data), 16'(len));
    if (op == NFBHC_OP_READ) cmp_val(16'(rx.size()), 16'(len));
    foreach (rx[i]) cmp_val(16'(rx[i]), 16'(8'(col + i) ^ rw[7:0]));
  endtask

  // reset, then each scenario in turn
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    req = '0;
    fail_blk = 11'h009;
    busy_ns = 300;
    repeat (2) @(posedge sys_clk);
    cmp_val(16'(valid_cnt), 16'h0800);
    cmp_val({13'h0000, ce_n, wp_n, req_ready}, 16'h0005);
    rst_n <= 1'b1;
    // partial programs of one page until both limits refuse
    for (k = 0; k < 3; k++)
      do_req(NFBHC_OP_PROG, 11'h005, 5'h03, 10'($random(seed) & 255), 10'h002);
    for (k = 0; k < 4; k++)
      do_req(NFBHC_OP_PROG, 11'h005, 5'h03, 10'(512 + ($random(seed) & 15)), 10'h001);
    do_req(NFBHC_OP_ERASE, 11'h005, 5'h00, 10'h000, 10'h000);
    do_req(NFBHC_OP_PROG, 11'h005, 5'h03, 10'h010, 10'h001);
    // reads in each pointer region, random busy
    for (k = 0; k < 3; k++) begin
      busy_ns <= 100 + ($random(seed) & 1023);
      do_req(NFBHC_OP_READ, 11'h007, 5'(k), 10'(k * 256 + 5), 10'h003);
    end
    // failing program retires a block
    do_req(NFBHC_OP_PROG, 11'h009, 5'h01, 10'h000, 10'h001);
    do_req(NFBHC_OP_ERASE, 11'h009, 5'h00, 10'h000, 10'h000);
    do_req(NFBHC_OP_PROG, 11'h009, 5'h02, 10'h000, 10'h001);
    // block zero never fails and is never retired
    fail_blk <= 11'h000;
    do_req(NFBHC_OP_ERASE, 11'h000, 5'h00, 10'h000, 10'h000);
    do_req(NFBHC_OP_MARK, 11'h000, 5'h00, 10'h000, 10'h000);
    do_req(NFBHC_OP_STATUS, 11'h000, 5'h00, 10'h000, 10'h000);
    // scan marks push the valid count under its floor
    for (k = 0; k < 36; k++)
      do_req(NFBHC_OP_MARK, 11'(100 + k), 5'h00, 10'h000, 10'h000);
    do_req(NFBHC_OP_MARK, 11'h064, 5'h00, 10'h000, 10'h000);
    do_req(NFBHC_OP_ERASE, 11'h065, 5'h00, 10'h000, 10'h000);
    end_sim();
  end
endmodule // nfbhc_top_bench
